// [event_filter_buffer_regs.svh]
`ifndef EVENT_FILTER_BUFFER_REGS_SVH
`define EVENT_FILTER_BUFFER_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define EVENT_BUFFER_WINDOW_LO 16'h0000
`define EVENT_BUFFER_WINDOW_HI 16'h07FC
`define THRESHOLD_TABLE_LO 16'h1080
`define THRESHOLD_TABLE_HI 16'h10BF
`define INC_EVENT_OFFSET 16'h1028
`define INC_WORD_OFFSET 16'h102C
`define STATUS_ONE_OFFSET 16'h100E
`define STATUS_TWO_OFFSET 16'h1022

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define THR_VALUE_MSB 7
`define THR_DISABLE_BIT 8
`define DATA_OVERRANGE_BIT 12
`define DATA_BELOW_LIMIT_BIT 13
`define WORD_TYPE_LSB 24
`define TYPE_DATA 3'h0
`define TYPE_HEADER 3'h2
`define TYPE_TRAILER 3'h4
`define STAT_EMPTY_BIT 1
`define STAT_FULL_BIT 2
`define STAT_BUSY_BIT 0

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define VALID_CODE_MAX 12'hF00
`define THRESHOLD_RESET 16'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SETTLE_TIME_NS 600
`define CLEAR_TIME_NS 600
`define CLK_PERIOD_NS 5

`endif

// [event_filter_buffer_pkg.sv]
package event_filter_buffer_pkg;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ACQUIRE = 6'b000010,
    ST_SETTLE = 6'b000100,
    ST_DIGITISE = 6'b001000,
    ST_FRAME = 6'b010000,
    ST_CLEAR = 6'b100000
  } seq_state_type;

  typedef enum logic [0:0] {
    LAST_READ = 1'b0,
    LAST_WRITE = 1'b1
  } last_inc_type;

endpackage : event_filter_buffer_pkg

// [event_filter_buffer.sv]
`timescale 1ns/1ps
`include "event_filter_buffer_regs.svh"
module event_filter_buffer #(
  parameter int CHANNELS = 32,
  parameter int EVENTS = 32,
  parameter int SLOT_WORDS = 34,
  parameter int GROUP = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic gate_in,
  input wire logic data_clear,
  input wire logic keep_low_values,
  input wire logic keep_overrange,
  input wire logic threshold_step_select,
  input wire logic auto_advance,
  input wire logic store_empty_events,
  input wire logic slide_enable,
  input wire logic [11:0] conv_a_code,
  input wire logic conv_a_overflow,
  input wire logic [11:0] conv_b_code,
  input wire logic conv_b_overflow,
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  output logic peak_capture,
  output logic discharge,
  output logic [3:0] mux_select,
  output logic [1:0] mux_group,
  output logic [7:0] slide_offset,
  output logic busy,
  output logic buffer_full,
  output logic buffer_empty
);
  import event_filter_buffer_pkg::*;

  localparam int SETTLE_CYC = (`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int CLEAR_CYC = (`CLEAR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int HALF = CHANNELS / 2;

  function automatic int buf_index(input logic [4:0] slot, input logic [5:0] off);
    buf_index = int'(slot) * SLOT_WORDS + int'(off);
  endfunction : buf_index

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // event slot storage
  logic [31:0] buffer_mem [EVENTS*SLOT_WORDS];
  logic [5:0] slot_len_reg [EVENTS];
  logic [15:0] threshold_reg [CHANNELS];
  logic [CHANNELS-1:0] thr_set_reg = '0;

  seq_state_type state_reg;
  seq_state_type state_next;
  logic [7:0] time_cnt_reg;
  logic [4:0] chan_reg;
  logic [5:0] word_cnt_reg;
  logic frame_trailer_reg;
  logic [4:0] wr_slot_reg;
  logic [4:0] rd_slot_reg;
  logic [5:0] rd_off_reg;
  last_inc_type last_inc_reg;
  logic [7:0] event_count_reg;

  // ----------------------------------------------------------------
  // buffer status
  // ----------------------------------------------------------------
  logic slots_equal;
  assign slots_equal = (wr_slot_reg == rd_slot_reg);
  assign buffer_full = slots_equal && (last_inc_reg == LAST_WRITE);
  assign buffer_empty = slots_equal && (last_inc_reg == LAST_READ);
  assign busy = (state_reg != ST_IDLE) || buffer_full;

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  logic settle_done;
  logic clear_done;
  logic digi_done;
  logic commit;
  assign settle_done = (time_cnt_reg == 8'(SETTLE_CYC - 1));
  assign clear_done = (time_cnt_reg == 8'(CLEAR_CYC - 1));
  assign digi_done = (chan_reg == 5'(CHANNELS - 1));
  assign commit = (word_cnt_reg != 6'h00) || store_empty_events;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (gate_in && !buffer_full) state_next = ST_ACQUIRE;
      ST_ACQUIRE: if (!gate_in) state_next = ST_SETTLE;
      ST_SETTLE: if (settle_done) state_next = ST_DIGITISE;
      ST_DIGITISE: if (digi_done) state_next = ST_FRAME;
      ST_FRAME: if (frame_trailer_reg || !commit) state_next = ST_CLEAR;
      ST_CLEAR: if (clear_done) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst || data_clear) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || state_reg != state_next) begin
      time_cnt_reg <= 8'h00;
    end else begin
      time_cnt_reg <= time_cnt_reg + 8'h01;
    end
  end

  assign peak_capture = (state_reg == ST_ACQUIRE) && gate_in;
  assign discharge = (state_reg == ST_CLEAR);
  logic [3:0] in_block;
  assign in_block = 4'(int'(chan_reg) % HALF);
  assign mux_select = in_block;
  assign mux_group = 2'(int'(in_block) / GROUP);

  // ----------------------------------------------------------------
  // sliding scale and zero suppression
  // ----------------------------------------------------------------
  logic [11:0] raw_code;
  logic raw_ovf;
  logic [12:0] diff;
  logic [11:0] code;
  logic ovf;
  logic [15:0] thr;
  logic [7:0] thr_val;
  logic below;
  logic keep;
  logic [31:0] data_word;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      slide_offset <= 8'h00;
    end else if (state_reg == ST_CLEAR && clear_done) begin
      slide_offset <= slide_offset + 8'h01;
    end
  end

  always_comb begin
    raw_code = (int'(chan_reg) >= HALF) ? conv_b_code : conv_a_code;
    raw_ovf = (int'(chan_reg) >= HALF) ? conv_b_overflow : conv_a_overflow;
    diff = {1'b0, raw_code} - (slide_enable ? {5'h00, slide_offset} : 13'h0000);
    code = diff[11:0];
    ovf = raw_ovf || (slide_enable && (diff[12] || code > `VALID_CODE_MAX));
    thr = thr_set_reg[chan_reg] ? threshold_reg[chan_reg] : `THRESHOLD_RESET;
    thr_val = thr[`THR_VALUE_MSB:0];
    if (threshold_step_select) begin
      below = (code[8:1] < thr_val) && (code[11:9] == 3'h0);
    end else begin
      below = code[11:4] < thr_val;
    end
    keep = !thr[`THR_DISABLE_BIT] && (!below || keep_low_values) && (!ovf || keep_overrange);
    data_word = {5'h00, `TYPE_DATA, 3'h0, chan_reg, 2'h0, below, ovf, code};
  end

  // ----------------------------------------------------------------
  // event framing and write pointer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst || state_reg == ST_IDLE) begin
      chan_reg <= 5'h00;
      word_cnt_reg <= 6'h00;
      frame_trailer_reg <= 1'b0;
    end else if (state_reg == ST_DIGITISE) begin
      if (!digi_done) chan_reg <= chan_reg + 5'h01;
      if (keep) word_cnt_reg <= word_cnt_reg + 6'h01;
    end else if (state_reg == ST_FRAME) begin
      frame_trailer_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (state_reg == ST_DIGITISE && keep) begin
      buffer_mem[buf_index(wr_slot_reg, word_cnt_reg + 6'h01)] <= data_word;
    end else if (state_reg == ST_FRAME && commit && !frame_trailer_reg) begin
      buffer_mem[buf_index(wr_slot_reg, 6'h00)] <= {5'h00, `TYPE_HEADER, 10'h000, word_cnt_reg, 8'h00};
    end else if (state_reg == ST_FRAME && commit) begin
      buffer_mem[buf_index(wr_slot_reg, word_cnt_reg + 6'h01)] <= {5'h00, `TYPE_TRAILER, 16'h0000, event_count_reg};
      slot_len_reg[wr_slot_reg] <= word_cnt_reg + 6'h02;
    end
  end

  logic wr_step;
  assign wr_step = (state_reg == ST_FRAME) && frame_trailer_reg && commit;

  always_ff @(posedge ref_clk) begin
    if (rst || data_clear) begin
      wr_slot_reg <= 5'h00;
      event_count_reg <= 8'h00;
    end else if (wr_step) begin
      wr_slot_reg <= 5'((int'(wr_slot_reg) + 1) % EVENTS);
      event_count_reg <= event_count_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // register access and read pointer
  // ----------------------------------------------------------------
  logic win_rd;
  logic thr_hit;
  logic [4:0] thr_idx;
  logic adv_word;
  logic adv_event;
  logic last_word;
  assign win_rd = reg_rd && (reg_addr <= `EVENT_BUFFER_WINDOW_HI);
  assign thr_hit = (reg_addr >= `THRESHOLD_TABLE_LO) && (reg_addr <= `THRESHOLD_TABLE_HI);
  assign thr_idx = reg_addr[5:1];
  assign last_word = (rd_off_reg == slot_len_reg[rd_slot_reg] - 6'h01);
  assign adv_word = !buffer_empty && ((win_rd && auto_advance) || (reg_wr && reg_addr == `INC_WORD_OFFSET));
  assign adv_event = !buffer_empty && ((adv_word && last_word) || (reg_wr && reg_addr == `INC_EVENT_OFFSET));

  always_ff @(posedge ref_clk) begin
    if (rst || data_clear) begin
      rd_slot_reg <= 5'h00;
      rd_off_reg <= 6'h00;
    end else if (adv_event) begin
      rd_slot_reg <= 5'((int'(rd_slot_reg) + 1) % EVENTS);
      rd_off_reg <= 6'h00;
    end else if (adv_word) begin
      rd_off_reg <= rd_off_reg + 6'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || data_clear) begin
      last_inc_reg <= LAST_READ;
    end else if (wr_step) begin
      last_inc_reg <= LAST_WRITE;
    end else if (adv_event) begin
      last_inc_reg <= LAST_READ;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reg_wr && thr_hit) begin
      threshold_reg[thr_idx] <= reg_wdata;
      thr_set_reg[thr_idx] <= 1'b1;
    end
  end

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h00000000;
    status_word[`STAT_BUSY_BIT] = busy;
    status_word[`STAT_EMPTY_BIT] = buffer_empty;
    status_word[`STAT_FULL_BIT] = buffer_full;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
      reg_ack <= 1'b0;
    end else begin
      reg_ack <= reg_rd || reg_wr;
      if (win_rd) begin
        reg_rdata <= buffer_empty ? 32'h00000000 : buffer_mem[buf_index(rd_slot_reg, rd_off_reg)];
      end else if (reg_rd && thr_hit) begin
        reg_rdata <= {16'h0000, thr_set_reg[thr_idx] ? threshold_reg[thr_idx] : `THRESHOLD_RESET};
      end else if (reg_rd && (reg_addr == `STATUS_ONE_OFFSET || reg_addr == `STATUS_TWO_OFFSET)) begin
        reg_rdata <= status_word;
      end else if (reg_rd) begin
        reg_rdata <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence settle_wait_s;
    (state_reg == ST_SETTLE) [*8];
  endsequence

  window_capture_a: assert property (@(posedge ref_clk) disable iff (rst)
    peak_capture |-> gate_in && state_reg == ST_ACQUIRE) else $error("capture outside window");
  phase_order_a: assert property (@(posedge ref_clk) disable iff (rst || data_clear)
    state_reg == ST_ACQUIRE && !gate_in |=> settle_wait_s) else $error("settle not after acquire");
  settle_time_a: assert property (@(posedge ref_clk) disable iff (rst || data_clear)
    state_reg == ST_ACQUIRE && !gate_in |-> ##120 state_reg == ST_SETTLE ##1 state_reg == ST_DIGITISE)
    else $error("settle time wrong");
  discharge_time_a: assert property (@(posedge ref_clk) disable iff (rst || data_clear)
    $rose(discharge) |-> ##119 discharge ##1 !discharge && state_reg == ST_IDLE) else $error("discharge length wrong");
  busy_ignore_a: assert property (@(posedge ref_clk) disable iff (rst || data_clear)
    state_reg == ST_IDLE && buffer_full |=> state_reg == ST_IDLE) else $error("window taken while full");
  write_step_a: assert property (@(posedge ref_clk) disable iff (rst || data_clear)
    wr_step |=> wr_slot_reg == 5'($past(wr_slot_reg) + 5'h01) && !buffer_empty) else $error("write pointer stuck");
  full_status_a: assert property (@(posedge ref_clk) disable iff (rst)
    buffer_full |-> slots_equal && !buffer_empty) else $error("full flag inconsistent");
  full_after_write_a: assert property (@(posedge ref_clk) disable iff (rst || data_clear)
    $rose(buffer_full) |-> $past(wr_step)) else $error("full without write step");
  not_empty_a: assert property (@(posedge ref_clk) disable iff (rst)
    !slots_equal |-> !buffer_full && !buffer_empty) else $error("status wrong with slots apart");
  clear_data_a: assert property (@(posedge ref_clk) disable iff (rst)
    data_clear |=> buffer_empty && wr_slot_reg == 5'h00 && rd_slot_reg == 5'h00) else $error("data clear failed");
  drop_empty_a: assert property (@(posedge ref_clk) disable iff (rst || data_clear)
    state_reg == ST_FRAME && word_cnt_reg == 6'h00 && !store_empty_events |=> wr_slot_reg == $past(wr_slot_reg))
    else $error("empty event stored");
  disable_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == ST_DIGITISE && thr[`THR_DISABLE_BIT] |=> word_cnt_reg == $past(word_cnt_reg))
    else $error("disabled channel stored");
  overflow_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == ST_DIGITISE && ovf && !keep_overrange |=> word_cnt_reg == $past(word_cnt_reg))
    else $error("overflow stored");

endmodule : event_filter_buffer

// [conv_model.sv]
`timescale 1ns/1ps
module conv_model (
  input wire logic [3:0] mux_select,
  input wire logic [1:0] mux_group,
  input wire logic [7:0] slide_offset,
  input wire logic slide_enable,
  input wire logic [11:0] codes [32],
  input wire logic [31:0] ovf,
  output logic [11:0] conv_a_code,
  output logic conv_a_overflow,
  output logic [11:0] conv_b_code,
  output logic conv_b_overflow
);
  logic [11:0] add;
  assign add = slide_enable ? {4'h0, slide_offset} : 12'h000;
  // block a low half
  // group lines must agree with the select, else the result reads as overflow
  assign conv_a_code = codes[{1'b0, mux_group, mux_select[1:0]}] + add;
  assign conv_a_overflow = ovf[{1'b0, mux_group, mux_select[1:0]}] || (mux_select[3:2] != mux_group);
  assign conv_b_code = codes[{1'b1, mux_group, mux_select[1:0]}] + add;
  assign conv_b_overflow = ovf[{1'b1, mux_group, mux_select[1:0]}] || (mux_select[3:2] != mux_group);
endmodule : conv_model

// [event_filter_buffer_tb.sv]
`timescale 1ns/1ps
module event_filter_buffer_tb;
  logic ref_clk = 0, rst = 1, gate_in = 0, data_clear = 0, keep_low_values = 0, keep_overrange = 0;
  logic threshold_step_select = 0, auto_advance = 0, store_empty_events = 0, slide_enable = 0;
  logic [11:0] conv_a_code, conv_b_code, codes [32];
  logic conv_a_overflow, conv_b_overflow, reg_rd = 0, reg_wr = 0, reg_ack, peak_capture, discharge;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000;
  logic [31:0] reg_rdata, ovf = 32'h0, d;
  logic [3:0] mux_select;
  logic [1:0] mux_group;
  logic [7:0] slide_offset;
  logic busy, buffer_full, buffer_empty;
  logic [31:0] q [$];
  int mismatches = 0, n_checks = 0;

  always #2.5 ref_clk = ~ref_clk;

  event_filter_buffer event_filter_buffer_inst (.ref_clk(ref_clk), .rst(rst), .gate_in(gate_in),
    .data_clear(data_clear), .keep_low_values(keep_low_values), .keep_overrange(keep_overrange),
    .threshold_step_select(threshold_step_select), .auto_advance(auto_advance),
    .store_empty_events(store_empty_events), .slide_enable(slide_enable), .conv_a_code(conv_a_code),
    .conv_a_overflow(conv_a_overflow), .conv_b_code(conv_b_code), .conv_b_overflow(conv_b_overflow),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .peak_capture(peak_capture), .discharge(discharge), .mux_select(mux_select),
    .mux_group(mux_group), .slide_offset(slide_offset), .busy(busy), .buffer_full(buffer_full),
    .buffer_empty(buffer_empty));

  conv_model conv_model_inst (.mux_select(mux_select), .mux_group(mux_group), .slide_offset(slide_offset),
    .slide_enable(slide_enable), .codes(codes), .ovf(ovf), .conv_a_code(conv_a_code),
    .conv_a_overflow(conv_a_overflow), .conv_b_code(conv_b_code), .conv_b_overflow(conv_b_overflow));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    if (mismatches == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    #1 reg_addr = a;
    reg_wdata = v;
    reg_rd = !w;
    reg_wr = w;
    @(posedge ref_clk);
    #1 reg_rd = 0;
    reg_wr = 0;
    chk(reg_ack, 1);
    d = reg_rdata;
  endtask : acc

  function automatic logic [31:0] dw(input int ch, input logic [11:0] c, input logic lo, input logic ov);
    return {11'h0, ch[4:0], 2'b00, lo, ov, c};
  endfunction : dw

  task automatic fire(input logic eb);
    int n;
    @(posedge ref_clk);
    #1 gate_in = 1;
    repeat (3) @(posedge ref_clk);
    #1 chk(peak_capture, 1);
    gate_in = 0;
    n = 0;
    while (discharge !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk(n > 150 && n < 160, 1);
    n = 0;
    while (discharge === 1'b1 && n < 400) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk(n, 120);
    chk(busy, eb);
  endtask : fire

  task automatic get_event();
    acc(0, 16'h0000, 16'h0);
    chk(d[26:24], 3'h2);
    chk(d[13:8], q.size());
    if (!auto_advance) acc(1, 16'h102C, 16'h0);
    foreach (q[i]) begin
      acc(0, 16'h0000, 16'h0);
      chk(d, q[i]);
      if (!auto_advance) acc(1, 16'h102C, 16'h0);
    end
    acc(0, 16'h0000, 16'h0);
    chk(d[26:24], 3'h4);
    if (!auto_advance) acc(1, 16'h1028, 16'h0);
  endtask : get_event

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_setup();
    chk({busy, buffer_full, buffer_empty}, 3'b001);
    acc(0, 16'h100E, 16'h0);
    chk(d[2:0], 3'b010);
    acc(0, 16'h1022, 16'h0);
    chk(d[2:0], 3'b010);
    acc(0, 16'h10A2, 16'h0);
    chk(d[8:0], 9'h000);
    for (int c = 0; c < 32; c++) acc(1, 16'h1080 + 16'(2 * c), 16'h01FF);
    acc(1, 16'h1080, 16'h00FF);
    acc(1, 16'h1082, 16'h00FF);
    acc(1, 16'h1086, 16'h0000);
    acc(1, 16'h10A2, 16'h0010);
    acc(0, 16'h1084, 16'h0);
    chk(d[8:0], 9'h1FF);
  endtask : s_setup

  task automatic s_coarse();
    codes[0] = 12'hFF0;
    codes[1] = 12'hFEF;
    codes[2] = 12'hFFF;
    codes[3] = 12'h800;
    codes[17] = 12'h100;
    ovf[3] = 1;
    fire(0);
    chk(buffer_empty, 0);
    q = '{dw(0, 12'hFF0, 0, 0), dw(17, 12'h100, 0, 0)};
    get_event();
    chk(buffer_empty, 1);
    keep_low_values = 1;
    keep_overrange = 1;
    auto_advance = 1;
    fire(0);
    q = '{dw(0, 12'hFF0, 0, 0), dw(1, 12'hFEF, 1, 0), dw(3, 12'h800, 0, 1), dw(17, 12'h100, 0, 0)};
    get_event();
    chk(buffer_empty, 1);
  endtask : s_coarse

  task automatic s_fine();
    keep_low_values = 0;
    keep_overrange = 0;
    auto_advance = 0;
    threshold_step_select = 1;
    codes[0] = 12'h01F;
    codes[1] = 12'h200;
    ovf[3] = 0;
    fire(0);
    q = '{dw(1, 12'h200, 0, 0), dw(3, 12'h800, 0, 0), dw(17, 12'h100, 0, 0)};
    get_event();
  endtask : s_fine

  task automatic s_empty_slide();
    threshold_step_select = 0;
    codes[0] = 12'h000;
    codes[1] = 12'h000;
    codes[17] = 12'h000;
    ovf[3] = 1;
    fire(0);
    chk(buffer_empty, 1);
    store_empty_events = 1;
    fire(0);
    q.delete();
    get_event();
    store_empty_events = 0;
    slide_enable = 1;
    codes[0] = 12'hFF5;
    codes[17] = 12'h100;
    fire(0);
    q = '{dw(17, 12'h100, 0, 0)};
    get_event();
    slide_enable = 0;
    codes[0] = 12'h000;
  endtask : s_empty_slide

  task automatic s_full();
    for (int i = 0; i < 32; i++) fire(i == 31);
    chk(buffer_full, 1);
    acc(0, 16'h100E, 16'h0);
    chk(d[2:0], 3'b101);
    acc(0, 16'h1022, 16'h0);
    chk(d[2:0], 3'b101);
    @(posedge ref_clk);
    #1 gate_in = 1;
    repeat (3) @(posedge ref_clk);
    #1 chk(peak_capture, 0);
    gate_in = 0;
    repeat (200) @(posedge ref_clk);
    #1 chk({discharge, buffer_full}, 2'b01);
    get_event();
    chk({busy, buffer_full, buffer_empty}, 3'b000);
    data_clear = 1;
    @(posedge ref_clk);
    #1 data_clear = 0;
    chk({buffer_full, buffer_empty}, 2'b01);
    rst = 1;
    @(posedge ref_clk);
    #1 rst = 0;
    acc(0, 16'h10A2, 16'h0);
    chk(d[8:0], 9'h010);
  endtask : s_full

  initial begin
    foreach (codes[i]) codes[i] = 12'h000;
    repeat (12) @(posedge ref_clk);
    #1 rst = 0;
    s_setup();
    s_coarse();
    s_fine();
    s_empty_slide();
    s_full();
    summarize();
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    summarize();
  end
endmodule : event_filter_buffer_tb
